// ===== shared/pdbc_pkg.sv
/*
  constants, register map and carrier types of the pulse unit that holds
  the wide 12-bit channel and the two byte channels.
  assumes a single clock and an 8-bit register port run by a bus master.
*/
//
// Summary of operation
// - wide duty split over low byte and nibble
// - wide period not above duty, polarity 0: high
// - wide period not above duty, polarity 1: low
// - new period and duty take effect next period
// - pin driven only after its enable bit set
// - overflow sets flag; only writing 0 clears
// - request needs channel enable and global enable
// - polarity bit inverts active duty level
// - selector divides oscillator by 2/4/8/16
// - channel b selector resets to divide by 2
// - two independent byte channels, own registers
// - channel a period is 8 bits, resets zero
// - period length is period times prescaled clock
// - zero period holds inactive level
// - pulse registers writable only with key 55h
package pdbc_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hC8;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hC9;
  localparam logic [7:0] ADDR_IRQ_GLOBAL = 8'hCA;
  localparam logic [7:0] ADDR_UNIT_ENABLE = 8'hCF;
  localparam logic [7:0] ADDR_WIDE_CONTROL = 8'hD2;
  localparam logic [7:0] ADDR_WIDE_PER_LOW = 8'hD3;
  localparam logic [7:0] ADDR_WIDE_PER_HIGH = 8'hD4;
  localparam logic [7:0] ADDR_WIDE_DUTY_LOW = 8'hD5;
  localparam logic [7:0] ADDR_WIDE_DUTY_HIGH = 8'hD6;
  localparam logic [7:0] ADDR_A_CONTROL = 8'hD9;
  localparam logic [7:0] ADDR_A_PERIOD = 8'hDA;
  localparam logic [7:0] ADDR_A_DUTY = 8'hDB;
  localparam logic [7:0] ADDR_B_CONTROL = 8'hDD;
  localparam logic [7:0] ADDR_B_PERIOD = 8'hDE;
  localparam logic [7:0] ADDR_B_DUTY = 8'hDF;
  localparam logic [7:0] ADDR_LOCK_KEY = 8'hE7;

  // ****************************************************************
  // fields and values
  // ****************************************************************
  localparam int CTRL_IE_BIT = 7;
  localparam int CTRL_IF_BIT = 6;
  localparam int CTRL_POL_BIT = 2;
  localparam int CTRL_SEL_LSB = 0;
  localparam int CH_WIDE = 0;
  localparam int CH_A = 1;
  localparam int CH_B = 2;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hC7;
  localparam logic [7:0] LOCK_KEY = 8'h55;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pdbc_bus_t;

  typedef struct packed {
    logic [7:0] lock;
    logic [2:0] unit_en;
    logic [7:0] w_ctl;
    logic [11:0] w_per;
    logic [11:0] w_duty;
    logic [7:0] a_ctl;
    logic [7:0] a_per;
    logic [7:0] a_duty;
    logic [7:0] b_ctl;
    logic [7:0] b_per;
    logic [7:0] b_duty;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic gie;
    logic [7:0] rdata;
    logic irq;
    logic [2:0] pin_oe;
  } pdbc_regs_t;

endpackage

// ===== design/pdbc_top.sv
/*
  pulse unit: one 12-bit channel and two byte channels, their register
  file behind an 8-bit port, write key protection and interrupt logic.
  assumes the register master obeys the one-cycle strobe protocol and
  that all inputs are on clk.
*/
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps

// ******************************************************************
// one pulse channel
// ******************************************************************
module pdbc_chan #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [W-1:0] per_in,
  input wire logic [W-1:0] duty_in,
  input wire logic pol_in,
  input wire logic [1:0] sel_in,
  output logic pwm,
  output logic ovf
);

  typedef struct packed {
    logic [3:0] div;
    logic [W-1:0] cnt;
    logic [W-1:0] per;
    logic [W-1:0] duty;
    logic pol;
    logic [1:0] sel;
    logic pwm;
    logic ovf;
  } pdbc_chan_state_t;

  pdbc_chan_state_t st;
  pdbc_chan_state_t next_st;
  logic [3:0] lim;
  logic tick;
  logic last;
  logic wrap;

  function automatic logic active(input logic [W-1:0] c,
                                  input logic [W-1:0] p,
                                  input logic [W-1:0] d);
    if (p == '0) begin
      active = 1'b0;
    end else if (p <= d) begin
      active = 1'b1;
    end else begin
      active = c < d;
    end
  endfunction

  always_comb begin
    next_st = st;
    next_st.ovf = 1'b0;
    // divider limit 1, 3, 7 or 15
    lim = 4'((5'h02 << st.sel) - 5'h01);
    tick = st.div == lim;
    last = (st.per == '0) || (W'(st.cnt + W'(1)) >= st.per);
    wrap = tick && last;
    if (!run) begin
      // idle channel tracks the registers so it starts clean
      next_st.div = 4'h0;
      next_st.cnt = '0;
      next_st.per = per_in;
      next_st.duty = duty_in;
      next_st.pol = pol_in;
      next_st.sel = sel_in;
    end else begin
      next_st.div = tick ? 4'h0 : 4'(st.div + 4'h1);
      if (wrap) begin
        // shadows reload only at period start
        next_st.cnt = '0;
        next_st.per = per_in;
        next_st.duty = duty_in;
        next_st.pol = pol_in;
        next_st.sel = sel_in;
        next_st.ovf = 1'b1;
      end else if (tick) begin
        next_st.cnt = W'(st.cnt + W'(1));
      end
    end
    next_st.pwm = active(next_st.cnt, next_st.per, next_st.duty)
                  ^ next_st.pol;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pwm = st.pwm;
  assign ovf = st.ovf;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_zero_per_idle: assert property (
    next_st.per == '0 |-> next_st.pwm == next_st.pol)
    else $error("zero period not at inactive level");
  a_full_duty_high: assert property (
    next_st.per != '0 && next_st.per <= next_st.duty && !next_st.pol
    |-> next_st.pwm)
    else $error("full duty with polarity 0 not high");
  a_full_duty_low: assert property (
    next_st.per != '0 && next_st.per <= next_st.duty && next_st.pol
    |-> !next_st.pwm)
    else $error("full duty with polarity 1 not low");
  a_duty_level: assert property (
    next_st.per > next_st.duty && next_st.cnt < next_st.duty
    |-> next_st.pwm == !next_st.pol)
    else $error("duty time level wrong");
  a_shadow_hold: assert property (
    run && !wrap |=> $stable(st.per) && $stable(st.duty))
    else $error("shadow changed inside a period");
  a_div_two: assert property (
    run && tick && !wrap && st.sel == 2'h0 ##1 run
    |-> !tick ##1 tick)
    else $error("divide by two spacing wrong");
  a_count_step: assert property (
    run && tick && !wrap |=> st.cnt == W'($past(st.cnt) + W'(1)))
    else $error("counter did not step");
  a_wrap_ovf: assert property (
    run && wrap |=> st.ovf && st.cnt == '0)
    else $error("wrap did not restart and flag");

  c_wrap: cover property (run && wrap);
  c_div16: cover property (run && tick && st.sel == 2'h3);

endmodule

// ******************************************************************
// top: register file, key, interrupts and the three channels
// ******************************************************************
module pdbc_top (
  input wire logic clk,
  input wire logic srst,
  input wire pdbc_pkg::pdbc_bus_t bus,
  output logic [7:0] rdata,
  output logic wide_pwm,
  output logic chan_a_pwm,
  output logic chan_b_pwm,
  output logic [2:0] pwm_oe,
  output logic irq
);

  pdbc_pkg::pdbc_regs_t st;
  pdbc_pkg::pdbc_regs_t next_st;
  logic unlocked;
  logic wr_ok;
  logic [2:0] ovf;
  logic [2:0] ie;
  logic [7:0] rmux;

  function automatic logic [7:0] ctl_wr(input logic [7:0] old,
                                        input logic [7:0] d);
    ctl_wr = d & pdbc_pkg::CTRL_WRITE_MASK;
    // writing 1 to the flag leaves it as it was
    ctl_wr[pdbc_pkg::CTRL_IF_BIT] = old[pdbc_pkg::CTRL_IF_BIT]
                                    & d[pdbc_pkg::CTRL_IF_BIT];
  endfunction

  always_comb begin
    unique case (bus.addr)
      pdbc_pkg::ADDR_IRQ_STATUS: rmux = {5'h00, st.irq_st};
      pdbc_pkg::ADDR_IRQ_MASK: rmux = {5'h00, st.irq_mask};
      pdbc_pkg::ADDR_IRQ_GLOBAL: rmux = {7'h00, st.gie};
      pdbc_pkg::ADDR_UNIT_ENABLE: rmux = {5'h00, st.unit_en};
      pdbc_pkg::ADDR_WIDE_CONTROL: rmux = st.w_ctl;
      pdbc_pkg::ADDR_WIDE_PER_LOW: rmux = st.w_per[7:0];
      pdbc_pkg::ADDR_WIDE_PER_HIGH: rmux = {4'h0, st.w_per[11:8]};
      pdbc_pkg::ADDR_WIDE_DUTY_LOW: rmux = st.w_duty[7:0];
      pdbc_pkg::ADDR_WIDE_DUTY_HIGH: rmux = {4'h0, st.w_duty[11:8]};
      pdbc_pkg::ADDR_A_CONTROL: rmux = st.a_ctl;
      pdbc_pkg::ADDR_A_PERIOD: rmux = st.a_per;
      pdbc_pkg::ADDR_A_DUTY: rmux = st.a_duty;
      pdbc_pkg::ADDR_B_CONTROL: rmux = st.b_ctl;
      pdbc_pkg::ADDR_B_PERIOD: rmux = st.b_per;
      pdbc_pkg::ADDR_B_DUTY: rmux = st.b_duty;
      pdbc_pkg::ADDR_LOCK_KEY: rmux = st.lock;
      default: rmux = pdbc_pkg::RESET_BYTE;
    endcase
  end

  always_comb begin
    next_st = st;
    // key gates every pulse setting register
    unlocked = st.lock == pdbc_pkg::LOCK_KEY;
    wr_ok = bus.wr && unlocked;
    if (bus.wr && bus.addr == pdbc_pkg::ADDR_LOCK_KEY) begin
      next_st.lock = bus.wdata;
    end
    if (bus.wr && bus.addr == pdbc_pkg::ADDR_IRQ_MASK) begin
      next_st.irq_mask = bus.wdata[2:0];
    end
    if (bus.wr && bus.addr == pdbc_pkg::ADDR_IRQ_GLOBAL) begin
      next_st.gie = bus.wdata[0];
    end
    if (wr_ok) begin
      unique case (bus.addr)
        pdbc_pkg::ADDR_UNIT_ENABLE: next_st.unit_en = bus.wdata[2:0];
        pdbc_pkg::ADDR_WIDE_CONTROL:
          next_st.w_ctl = ctl_wr(st.w_ctl, bus.wdata);
        pdbc_pkg::ADDR_WIDE_PER_LOW: next_st.w_per[7:0] = bus.wdata;
        pdbc_pkg::ADDR_WIDE_PER_HIGH: next_st.w_per[11:8] = bus.wdata[3:0];
        // duty split into low byte and high nibble
        pdbc_pkg::ADDR_WIDE_DUTY_LOW: next_st.w_duty[7:0] = bus.wdata;
        pdbc_pkg::ADDR_WIDE_DUTY_HIGH:
          next_st.w_duty[11:8] = bus.wdata[3:0];
        // separate register set per byte channel
        pdbc_pkg::ADDR_A_CONTROL:
          next_st.a_ctl = ctl_wr(st.a_ctl, bus.wdata);
        // full 8-bit period for channel a
        pdbc_pkg::ADDR_A_PERIOD: next_st.a_per = bus.wdata;
        pdbc_pkg::ADDR_A_DUTY: next_st.a_duty = bus.wdata;
        pdbc_pkg::ADDR_B_CONTROL:
          next_st.b_ctl = ctl_wr(st.b_ctl, bus.wdata);
        pdbc_pkg::ADDR_B_PERIOD: next_st.b_per = bus.wdata;
        pdbc_pkg::ADDR_B_DUTY: next_st.b_duty = bus.wdata;
        default: begin
        end
      endcase
    end
    // hardware set beats a same-cycle clear
    next_st.w_ctl[pdbc_pkg::CTRL_IF_BIT] =
      next_st.w_ctl[pdbc_pkg::CTRL_IF_BIT] | ovf[pdbc_pkg::CH_WIDE];
    next_st.a_ctl[pdbc_pkg::CTRL_IF_BIT] =
      next_st.a_ctl[pdbc_pkg::CTRL_IF_BIT] | ovf[pdbc_pkg::CH_A];
    next_st.b_ctl[pdbc_pkg::CTRL_IF_BIT] =
      next_st.b_ctl[pdbc_pkg::CTRL_IF_BIT] | ovf[pdbc_pkg::CH_B];
    // status is write-one-to-clear, set wins
    if (bus.wr && bus.addr == pdbc_pkg::ADDR_IRQ_STATUS) begin
      next_st.irq_st = st.irq_st & ~bus.wdata[2:0];
    end
    next_st.irq_st = next_st.irq_st | ovf;
    // channel enable and global enable both needed
    next_st.irq = next_st.gie
                  & (|(next_st.irq_st & next_st.irq_mask & ie));
    // pin handed over only by its enable bit
    next_st.pin_oe = next_st.unit_en;
    next_st.rdata = bus.rd ? rmux : pdbc_pkg::RESET_BYTE;
  end

  assign ie = {st.b_ctl[pdbc_pkg::CTRL_IE_BIT],
               st.a_ctl[pdbc_pkg::CTRL_IE_BIT],
               st.w_ctl[pdbc_pkg::CTRL_IE_BIT]};

  always_ff @(posedge clk) begin
    if (srst) begin
      // every selector resets to divide by two
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // channels
  // ****************************************************************
  // a period that ends between the low and high write of the wide
  // channel loads a half-updated value; the write order keeps it brief
  pdbc_chan #(.W(12)) u_wide (
    .clk(clk),
    .srst(srst),
    .run(st.unit_en[pdbc_pkg::CH_WIDE]),
    .per_in(st.w_per),
    .duty_in(st.w_duty),
    .pol_in(st.w_ctl[pdbc_pkg::CTRL_POL_BIT]),
    .sel_in(st.w_ctl[pdbc_pkg::CTRL_SEL_LSB +: 2]),
    .pwm(wide_pwm),
    .ovf(ovf[pdbc_pkg::CH_WIDE])
  );

  pdbc_chan #(.W(8)) u_chan_a (
    .clk(clk),
    .srst(srst),
    .run(st.unit_en[pdbc_pkg::CH_A]),
    .per_in(st.a_per),
    .duty_in(st.a_duty),
    .pol_in(st.a_ctl[pdbc_pkg::CTRL_POL_BIT]),
    .sel_in(st.a_ctl[pdbc_pkg::CTRL_SEL_LSB +: 2]),
    .pwm(chan_a_pwm),
    .ovf(ovf[pdbc_pkg::CH_A])
  );

  pdbc_chan #(.W(8)) u_chan_b (
    .clk(clk),
    .srst(srst),
    .run(st.unit_en[pdbc_pkg::CH_B]),
    .per_in(st.b_per),
    .duty_in(st.b_duty),
    .pol_in(st.b_ctl[pdbc_pkg::CTRL_POL_BIT]),
    .sel_in(st.b_ctl[pdbc_pkg::CTRL_SEL_LSB +: 2]),
    .pwm(chan_b_pwm),
    .ovf(ovf[pdbc_pkg::CH_B])
  );

  assign rdata = st.rdata;
  assign pwm_oe = st.pin_oe;
  assign irq = st.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_locked_period: assert property (
    bus.wr && bus.addr == pdbc_pkg::ADDR_A_PERIOD && !unlocked
    |=> $stable(st.a_per))
    else $error("locked period write took effect");
  a_duty_low_write: assert property (
    bus.wr && bus.addr == pdbc_pkg::ADDR_WIDE_DUTY_LOW && unlocked
    |=> st.w_duty[7:0] == $past(bus.wdata))
    else $error("wide duty low byte not stored");
  a_flag_set: assert property (
    ovf[pdbc_pkg::CH_A] |=> st.a_ctl[pdbc_pkg::CTRL_IF_BIT])
    else $error("overflow did not set flag");
  a_flag_keep: assert property (
    st.b_ctl[pdbc_pkg::CTRL_IF_BIT]
    && !(bus.wr && bus.addr == pdbc_pkg::ADDR_B_CONTROL)
    |=> st.b_ctl[pdbc_pkg::CTRL_IF_BIT])
    else $error("flag dropped without a clear");
  a_irq_gate: assert property (
    irq |-> $past(next_st.gie) && st.gie)
    else $error("interrupt without global enable");
  a_pin_enable: assert property (
    !st.unit_en[pdbc_pkg::CH_B] ##1 !st.unit_en[pdbc_pkg::CH_B]
    |-> !pwm_oe[pdbc_pkg::CH_B])
    else $error("pin driven while disabled");
  a_read_slot: assert property (
    !bus.rd |=> rdata == pdbc_pkg::RESET_BYTE)
    else $error("read data outside its slot");

  c_locked_try: cover property (bus.wr && !unlocked
    && bus.addr == pdbc_pkg::ADDR_A_DUTY);
  c_irq_rise: cover property ($rose(irq));
  c_ovf_clear: cover property (ovf[pdbc_pkg::CH_A] && bus.wr
    && bus.addr == pdbc_pkg::ADDR_A_CONTROL);

endmodule

// ===== dv/pdbc_load.sv
/*
  load seen by one pulse pin: measures high time and period in clocks.
  assumes the pin is sampled on clk and reset by srst.
*/
`timescale 1ns/1ps
module pdbc_load (
  input wire logic clk,
  input wire logic srst,
  input wire logic pin,
  output logic [15:0] hi_len,
  output logic [15:0] per_len,
  output logic [15:0] n_rise
);
  logic prev;
  logic [15:0] cnt;
  logic [15:0] hcnt;
  // ****************************************************************
  // edge timing
  // ****************************************************************
  // measured rise to rise, so a first partial period is never trusted
  always_ff @(posedge clk) begin
    if (srst) begin
      prev <= 1'b0;
      cnt <= 16'h0000;
      hcnt <= 16'h0000;
      hi_len <= 16'h0000;
      per_len <= 16'h0000;
      n_rise <= 16'h0000;
    end else begin
      prev <= pin;
      if (pin && !prev) begin
        per_len <= cnt;
        hi_len <= hcnt;
        cnt <= 16'h0001;
        hcnt <= 16'h0001;
        n_rise <= n_rise + 16'h0001;
      end else begin
        cnt <= cnt + 16'h0001;
        hcnt <= hcnt + {15'h0000, pin};
      end
    end
  end
endmodule

// ===== dv/pdbc_top_test.sv
/*
  self-checking bench of the pulse unit: register, key, waveform and
  interrupt scenarios.
  assumes pdbc_top and one pdbc_load on each output pin.
*/
`timescale 1ns/1ps
module pdbc_top_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  pdbc_pkg::pdbc_bus_t bus = '0;
  logic [7:0] rdata;
  logic wide_pwm;
  logic chan_a_pwm;
  logic chan_b_pwm;
  logic irq;
  logic [2:0] pwm_oe;
  logic [2:0] pins;
  logic [15:0] hi_len [3];
  logic [15:0] per_len [3];
  logic [15:0] n_rise [3];
  logic [7:0] rv;
  int n_mismatch = 0;
  int check_count = 0;

  assign pins = {chan_b_pwm, chan_a_pwm, wide_pwm};
  always #2 clk = ~clk;

  pdbc_top dut (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
    .wide_pwm(wide_pwm), .chan_a_pwm(chan_a_pwm),
    .chan_b_pwm(chan_b_pwm), .pwm_oe(pwm_oe), .irq(irq));

  for (genvar i = 0; i < 3; i++) begin : g_load
    pdbc_load load (.clk(clk), .srst(srst), .pin(pins[i]),
      .hi_len(hi_len[i]), .per_len(per_len[i]), .n_rise(n_rise[i]));
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [7:0] exp);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    rv = rdata;
    chk(nm, {8'h00, exp}, {8'h00, rv});
  endtask

  task automatic wait_rise(input int i, input int n);
    logic [15:0] start;
    int k;
    start = n_rise[i];
    k = 0;
    while (16'(n_rise[i] - start) < 16'(n) && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) begin
      n_mismatch++;
      $display("[ERR] rise wait expected %0d seen timeout", n);
      stop_test();
    end
  endtask

  // third rise ends the second interval that lies wholly after a reload
  task automatic meas(input int i, input int p, input int h);
    wait_rise(i, 3);
    chk("period", 16'(p), per_len[i]);
    chk("high time", 16'(h), hi_len[i]);
  endtask

  task automatic hold(input int i, input logic lvl);
    logic bad;
    bad = 1'b0;
    // a wide reload may wait a whole period of ten clocks
    repeat (16) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      #1;
      if (pins[i] !== lvl) bad = 1'b1;
    end
    chk("steady level", 16'h0001, {15'h0000, !bad});
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    if (k >= 200) begin
      n_mismatch++;
      $display("[ERR] irq wait expected 1 seen timeout");
      stop_test();
    end
    chk("irq raised", 16'h0001, {15'h0000, irq});
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rchk("duty low", 8'hD5, 8'h00);
    rchk("duty high", 8'hD6, 8'h00);
    rchk("ctl a", 8'hD9, 8'h00);
    rchk("period a", 8'hDA, 8'h00);
    rchk("ctl b", 8'hDD, 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    chk("pin enables", 16'h0000, {13'h0000, pwm_oe});
    wr(8'hDA, 8'h10);
    rchk("locked period", 8'hDA, 8'h00);
    wr(8'hE7, 8'h55);
    wr(8'hDA, 8'h04);
    rchk("period a", 8'hDA, 8'h04);
    wr(8'hD5, 8'hAB);
    wr(8'hD6, 8'hFC);
    rchk("duty low", 8'hD5, 8'hAB);
    rchk("duty high", 8'hD6, 8'h0C);
    wr(8'hDB, 8'h01);
    wr(8'hD9, 8'h00);
    wr(8'hCF, 8'h02);
    meas(1, 8, 2);
    chk("pin enables", 16'h0002, {13'h0000, pwm_oe});
    for (int s = 1; s < 4; s++) begin
      wr(8'hD9, 8'(s));
      meas(1, 8 << s, 2 << s);
    end
    wr(8'hD9, 8'h04);
    meas(1, 8, 6);
    wr(8'hD9, 8'h80);
    wr(8'hC9, 8'h02);
    wr(8'hCA, 8'h01);
    wait_irq();
    rchk("flag set", 8'hD9, 8'hC0);
    rchk("status", 8'hC8, 8'h02);
    wr(8'hCF, 8'h00);
    repeat (4) @(posedge clk);
    chk("irq sticky", 16'h0001, {15'h0000, irq});
    wr(8'hD9, 8'hC0);
    rchk("flag kept", 8'hD9, 8'hC0);
    wr(8'hD9, 8'h80);
    wr(8'hC8, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    wr(8'hCA, 8'h00);
    wr(8'hCF, 8'h02);
    repeat (30) @(posedge clk);
    chk("irq global off", 16'h0000, {15'h0000, irq});
    rchk("flag again", 8'hD9, 8'hC0);
    wr(8'hDD, 8'h04);
    wr(8'hCF, 8'h04);
    hold(2, 1'b1);
    wr(8'hDD, 8'h00);
    hold(2, 1'b0);
    wr(8'hD3, 8'h05);
    wr(8'hD4, 8'h00);
    wr(8'hD5, 8'h05);
    wr(8'hD6, 8'h00);
    wr(8'hD2, 8'h00);
    wr(8'hCF, 8'h01);
    hold(0, 1'b1);
    wr(8'hD2, 8'h04);
    hold(0, 1'b0);
    wr(8'hE7, 8'h00);
    wr(8'hDA, 8'h20);
    rchk("relocked period", 8'hDA, 8'h04);
    stop_test();
  end
endmodule
